// ---- hw/aefr_cfg.svh ----
// constants for the address error and frame return unit
`ifndef AEFR_CFG_SVH
`define AEFR_CFG_SVH

`define AEFR_AW          24
// exception vector numbers (plain defaults)
`define AEFR_VEC_BERR    8'h02
`define AEFR_VEC_AERR    8'h03
`define AEFR_VEC_FMTERR  8'h0e
// frame format codes
`define AEFR_FMT_SHORT   4'h0
`define AEFR_FMT_LONG    4'h8
// byte offsets of frame words from the stack pointer
`define AEFR_OFS_SR      8'h00
`define AEFR_OFS_PCH     8'h02
`define AEFR_OFS_PCL     8'h04
`define AEFR_OFS_FMT     8'h06
`define AEFR_OFS_SSW     8'h08
`define AEFR_OFS_FAH     8'h0a
`define AEFR_OFS_FAL     8'h0c
`define AEFR_OFS_VER     8'h1a
`define AEFR_OFS_LAST    8'h38
`define AEFR_OFS_STEP    8'h02
// bytes popped on a successful return
`define AEFR_POP_SHORT   8'h08
`define AEFR_POP_LONG    8'h3a
// fields of the special status word and the version word
`define AEFR_SSW_RERUN   15
`define AEFR_SSW_IFETCH  13
`define AEFR_SSW_DFETCH  12
`define AEFR_SSW_RMW     11
`define AEFR_SSW_HIBYTE  10
`define AEFR_SSW_BYTE    9
`define AEFR_SSW_READ    8
`define AEFR_VER_LSB     10
`define AEFR_VER_MSB     13
// register map (byte addresses)
`define AEFR_REG_CTRL    12'h000
`define AEFR_REG_STAT    12'h004
`define AEFR_REG_FADDR   12'h008
`define AEFR_REG_SSW     12'h00c
`define AEFR_CTRL_RST    32'h0000_0000

`endif

// ---- hw/aefr_pkg.sv ----
// types shared by the address error and frame return unit
`include "aefr_cfg.svh"
package aefr_pkg;
	typedef enum logic [1:0] {AEFR_SZ_BYTE = 2'b00, AEFR_SZ_WORD = 2'b01,
		AEFR_SZ_LONG = 2'b10} aefr_size_t;

	// one access request from the execution core
	typedef struct packed {
		logic                 valid;
		logic [`AEFR_AW-1:0]  addr;
		aefr_size_t           size;
		logic                 fetch;
		logic                 write;
		logic                 rmw;
		logic                 pmovUpper;
		logic [2:0]           fc;
	} aefr_access_t;

	// exception start request towards the stacking sequencer
	typedef struct packed {
		logic                 start;
		logic [7:0]           vector;
		logic                 longFrame;
		logic [15:0]          ssw;
		logic [`AEFR_AW-1:0]  faultAddr;
	} aefr_exc_t;

	typedef enum logic [2:0] {AEFR_IDLE = 3'b000, AEFR_HDR = 3'b001, AEFR_VER = 3'b010,
		AEFR_PROBE = 3'b011, AEFR_REST = 3'b100, AEFR_DONE = 3'b101} aefr_state_t;
endpackage : aefr_pkg

// ---- hw/aefr_exc_unit.sv ----
// address error detection and long frame return sequencer with apb status
// Function
// - odd word, long or fetch raises error
// - address error aborts cycle, starts exception
// - same frame as bus error, own vector
// - address error during group exception halts
// - address error stacks the full long frame
// - rerun clear retries stacked fault address
// - byte data low unless high-byte flag
// - return restores sr and pc, drops internal words, resumes
// - read sr, pc, format; short resumes
// - unknown format code gives format error
// - check version bits of word at 26
// - version mismatch gives format error
// - stack pointer unchanged until frame read
// - probe read of last word at 56
// - bus error up to probe: bus error
// - bus error after probe halts device
// - rerun flag zero reruns, one skips
// - halted until reset, no bus accesses
// - rerun repeats whole read-modify-write cycle
`timescale 1ns/1ps
`default_nettype none
`include "aefr_cfg.svh"
module aefr_exc_unit
	import aefr_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire aefr_access_t        coreAcc,
	input  wire logic                excBusy,
	input  wire logic                rteReq,
	input  wire logic [`AEFR_AW-1:0] stackPtr,
	output logic                     memReq,
	output logic [`AEFR_AW-1:0]      memAddr,
	input  wire logic                memAck,
	input  wire logic                memBerr,
	input  wire logic [15:0]         memData,
	output logic                     abortCycle,
	output aefr_exc_t                exc,
	output logic                     rteDone,
	output logic [15:0]              restSr,
	output logic [31:0]              restPc,
	output logic [`AEFR_AW-1:0]      newStackPtr,
	output logic                     retryReq,
	output logic [`AEFR_AW-1:0]      retryAddr,
	output logic                     retryRmw,
	output logic                     retryByte,
	output logic                     halted,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr
);
	// ----------------------------------------------------------------
	// misalignment decode
	// ----------------------------------------------------------------
	// odd non-byte check
	function automatic logic aefr_misaligned(input logic [`AEFR_AW-1:0] a,
		input logic isByte);
		aefr_misaligned = a[0] & ~isByte;
	endfunction : aefr_misaligned

	aefr_state_t                state;
	logic [7:0]                 ofs;
	logic [31:0]                ctrl;
	logic [15:0]                frameSsw;
	logic [`AEFR_AW-1:0]        frameFa;
	logic [3:0]                 frameFmt;
	logic                       coreMis;
	logic                       retryMis;
	logic                       aerrHit;
	logic                       berrHit;
	logic                       fmtHit;
	logic                       dblFault;
	logic [7:0]                 fmtErrCnt;
	logic [3:0]                 ownVersion;

	assign ownVersion = ctrl[3:0];
	assign coreMis  = coreAcc.valid & ~halted
		& aefr_misaligned(coreAcc.addr, coreAcc.size == AEFR_SZ_BYTE);
	// retried fault address is checked again
	assign retryMis = retryReq & aefr_misaligned(retryAddr, retryByte);
	assign aerrHit  = coreMis | retryMis;
	// bus error before or during the probe
	assign berrHit  = memBerr & memReq & (state != AEFR_REST);
	// bus error after a good probe
	assign dblFault = memBerr & memReq & (state == AEFR_REST);

	// ----------------------------------------------------------------
	// frame read port
	// ----------------------------------------------------------------
	// no read once halted
	assign memReq  = ~halted & (state inside {AEFR_HDR, AEFR_VER, AEFR_PROBE, AEFR_REST});
	assign memAddr = stackPtr + {{(`AEFR_AW-8){1'b0}}, ofs};

	// format errors from header and version word
	always_comb
	begin
		fmtHit = 1'b0;
		if (memReq & memAck & ~memBerr)
		begin
			if (state == AEFR_HDR && ofs == `AEFR_OFS_FMT)
				fmtHit = (memData[15:12] != `AEFR_FMT_SHORT)
					& (memData[15:12] != `AEFR_FMT_LONG);
			else if (state == AEFR_VER)
				fmtHit = memData[`AEFR_VER_MSB:`AEFR_VER_LSB] != ownVersion;
		end
	end

	// ----------------------------------------------------------------
	// return sequencer
	// ----------------------------------------------------------------
	// header, version, probe, rest
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= AEFR_IDLE;
			ofs   <= `AEFR_OFS_SR;
		end
		else if (halted | dblFault | berrHit | fmtHit)
		begin
			state <= AEFR_IDLE;
			ofs   <= `AEFR_OFS_SR;
		end
		else
		begin
			unique case (state)
				AEFR_IDLE:
					if (rteReq)
						state <= AEFR_HDR;
				AEFR_HDR:
					if (memAck)
					begin
						if (ofs != `AEFR_OFS_FMT)
							ofs <= ofs + `AEFR_OFS_STEP;
						else if (memData[15:12] == `AEFR_FMT_SHORT)
							state <= AEFR_DONE;
						else
						begin
							state <= AEFR_VER;
							ofs   <= `AEFR_OFS_VER;
						end
					end
				AEFR_VER:
					if (memAck)
					begin
						state <= AEFR_PROBE;
						ofs   <= `AEFR_OFS_LAST;
					end
				AEFR_PROBE:
					if (memAck)
					begin
						state <= AEFR_REST;
						ofs   <= `AEFR_OFS_SSW;
					end
				AEFR_REST:
					if (memAck)
					begin
						// last internal word sits just below the probed one
						if (ofs == `AEFR_OFS_LAST - `AEFR_OFS_STEP)
							state <= AEFR_DONE;
						else
							ofs <= ofs + `AEFR_OFS_STEP;
					end
				AEFR_DONE:
				begin
					state <= AEFR_IDLE;
					ofs   <= `AEFR_OFS_SR;
				end
			endcase
		end
	end

	// captured frame words, restSr and restPc load as each word is read, so a failed return can leave them changed
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			restSr   <= 16'h0000;
			restPc   <= 32'h0000_0000;
			frameFmt <= `AEFR_FMT_SHORT;
			frameSsw <= 16'h0000;
			frameFa  <= '0;
		end
		else if (memReq & memAck & ~memBerr)
		begin
			unique case (ofs)
				`AEFR_OFS_SR:  restSr         <= memData;
				`AEFR_OFS_PCH: restPc[31:16]  <= memData;
				`AEFR_OFS_PCL: restPc[15:0]   <= memData;
				`AEFR_OFS_FMT: frameFmt       <= memData[15:12];
				`AEFR_OFS_SSW: if (state == AEFR_REST) frameSsw <= memData;
				`AEFR_OFS_FAH: frameFa[`AEFR_AW-1:16] <= memData[`AEFR_AW-17:0];
				`AEFR_OFS_FAL: frameFa[15:0]  <= memData;
				default: ;
			endcase
		end
	end

	// pop and resume only after the whole frame
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rteDone     <= 1'b0;
			newStackPtr <= '0;
		end
		else
		begin
			rteDone <= (state == AEFR_DONE);
			// the popped pointer moves only once every frame word is in, so a
			// failed return leaves the old frame where the handler left it
			if (state == AEFR_DONE)
				newStackPtr <= stackPtr + {{(`AEFR_AW-8){1'b0}},
					(frameFmt == `AEFR_FMT_LONG) ? `AEFR_POP_LONG : `AEFR_POP_SHORT};
		end
	end

	// hardware rerun of the faulted cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			retryReq  <= 1'b0;
			retryAddr <= '0;
			retryRmw  <= 1'b0;
			retryByte <= 1'b0;
		end
		else
		begin
			retryReq  <= (state == AEFR_DONE) & (frameFmt == `AEFR_FMT_LONG)
				& ~frameSsw[`AEFR_SSW_RERUN];
			retryAddr <= frameFa;
			retryRmw  <= frameSsw[`AEFR_SSW_RMW];
			retryByte <= frameSsw[`AEFR_SSW_BYTE];
		end
	end

	// ----------------------------------------------------------------
	// exception launch and halt
	// ----------------------------------------------------------------
	// abort and stack with address error vector
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			exc        <= '0;
			abortCycle <= 1'b0;
		end
		else
		begin
			exc.start  <= 1'b0;
			abortCycle <= 1'b0;
			if (~halted & aerrHit & ~excBusy)
			begin
				abortCycle    <= 1'b1;
				exc.start     <= 1'b1;
				exc.vector    <= `AEFR_VEC_AERR;
				exc.longFrame <= 1'b1;
				exc.faultAddr <= coreMis ? coreAcc.addr : retryAddr;
				exc.ssw       <= '0;
				exc.ssw[`AEFR_SSW_HIBYTE] <= coreMis & coreAcc.pmovUpper;
				exc.ssw[`AEFR_SSW_BYTE]   <= coreMis ? (coreAcc.size == AEFR_SZ_BYTE)
					: retryByte;
				exc.ssw[`AEFR_SSW_RMW]    <= coreMis ? coreAcc.rmw : retryRmw;
				exc.ssw[`AEFR_SSW_READ]   <= ~(coreMis & coreAcc.write);
				exc.ssw[`AEFR_SSW_IFETCH] <= coreMis & coreAcc.fetch;
				exc.ssw[`AEFR_SSW_DFETCH] <= coreMis & ~coreAcc.fetch & ~coreAcc.write;
				exc.ssw[2:0]              <= coreMis ? coreAcc.fc : 3'h0;
			end
			else if (~halted & (berrHit | fmtHit))
			begin
				exc.start     <= 1'b1;
				exc.vector    <= berrHit ? `AEFR_VEC_BERR : `AEFR_VEC_FMTERR;
				exc.longFrame <= berrHit;
				exc.faultAddr <= memAddr;
				exc.ssw       <= '0;
				exc.ssw[`AEFR_SSW_READ] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			halted <= 1'b0;
		else if ((aerrHit & excBusy) | dblFault)
			halted <= 1'b1;
	end

	// ----------------------------------------------------------------
	// apb slave, zero wait states
	// ----------------------------------------------------------------
	assign pready = 1'b1;

	// control word: own frame version in the low nibble
	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl <= `AEFR_CTRL_RST;
		else if (psel & penable & pwrite & (paddr == `AEFR_REG_CTRL))
			ctrl <= {28'h0000000, pwdata[3:0]};
	end

	// saturating count of format errors, visible to software
	always_ff @(posedge clk)
	begin
		if (rst)
			fmtErrCnt <= 8'h00;
		else if (fmtHit & ~halted & (fmtErrCnt != 8'hff))
			fmtErrCnt <= fmtErrCnt + 8'h01;
	end

	// read data and error registered at the setup phase
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel & ~penable)
		begin
			pslverr <= 1'b0;
			unique case (paddr)
				`AEFR_REG_CTRL:  prdata <= ctrl;
				`AEFR_REG_STAT:  prdata <= {8'h00, fmtErrCnt, exc.vector,
					4'h0, 1'b0, state};
				`AEFR_REG_FADDR: prdata <= {{(32-`AEFR_AW){1'b0}}, exc.faultAddr};
				`AEFR_REG_SSW:   prdata <= {16'h0000, exc.ssw};
				default:
				begin
					prdata  <= 32'h0000_0000;
					pslverr <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_odd_raises;
		@(posedge clk) disable iff (rst)
		(coreMis & ~excBusy & ~halted) |=> (exc.start & exc.vector == `AEFR_VEC_AERR & abortCycle);
	endproperty
	a_odd_raises: assert property (p_odd_raises)
		else $error("odd access did not raise address error");

	property p_byte_never;
		@(posedge clk) disable iff (rst)
		(coreAcc.valid & coreAcc.size == AEFR_SZ_BYTE & ~retryMis & ~berrHit & ~fmtHit)
			|=> ~exc.start;
	endproperty
	a_byte_never: assert property (p_byte_never)
		else $error("byte access raised an exception");

	property p_halt_busy;
		@(posedge clk) disable iff (rst)
		(aerrHit & excBusy) |=> halted & ~exc.start;
	endproperty
	a_halt_busy: assert property (p_halt_busy)
		else $error("address error during exception did not halt");

	property p_halt_sticky;
		@(posedge clk) disable iff (rst)
		halted |=> halted & ~memReq & ~exc.start;
	endproperty
	a_halt_sticky: assert property (p_halt_sticky)
		else $error("left halt or accessed bus without reset");

	property p_dbl_fault;
		@(posedge clk) disable iff (rst)
		dblFault |=> halted ##1 halted;
	endproperty
	a_dbl_fault: assert property (p_dbl_fault)
		else $error("bus error after probe did not halt");

	property p_berr_early;
		@(posedge clk) disable iff (rst)
		(berrHit & ~halted) |=> exc.start & exc.vector == `AEFR_VEC_BERR & ~halted;
	endproperty
	a_berr_early: assert property (p_berr_early)
		else $error("early bus error not taken as bus error");

	property p_ver_bad;
		@(posedge clk) disable iff (rst)
		(state == AEFR_VER & memAck & ~memBerr
			& memData[`AEFR_VER_MSB:`AEFR_VER_LSB] != ownVersion)
			|=> exc.vector == `AEFR_VEC_FMTERR & state == AEFR_IDLE ##1 ~rteDone;
	endproperty
	a_ver_bad: assert property (p_ver_bad)
		else $error("version mismatch not a format error");

	property p_probe_addr;
		@(posedge clk) disable iff (rst)
		(state == AEFR_PROBE) |-> memAddr == stackPtr + `AEFR_AW'(`AEFR_OFS_LAST);
	endproperty
	a_probe_addr: assert property (p_probe_addr)
		else $error("probe not at last frame word");

	property p_sp_hold;
		@(posedge clk) disable iff (rst)
		(state != AEFR_DONE) |=> $stable(newStackPtr);
	endproperty
	a_sp_hold: assert property (p_sp_hold)
		else $error("stack pointer moved before the frame was read");

	property p_rerun;
		@(posedge clk) disable iff (rst)
		(state == AEFR_DONE & frameFmt == `AEFR_FMT_LONG) |=>
			(retryReq == ~$past(frameSsw[`AEFR_SSW_RERUN])) & rteDone;
	endproperty
	a_rerun: assert property (p_rerun)
		else $error("rerun flag not honoured");
endmodule : aefr_exc_unit
`default_nettype wire

// ---- bench/aefr_stack_mem.sv ----
// stack memory model that answers the unit's frame reads
`timescale 1ns/1ps
`default_nettype none
`include "aefr_cfg.svh"
module aefr_stack_mem
	import aefr_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                memReq,
	input  wire logic [`AEFR_AW-1:0] memAddr,
	input  wire logic [3:0]          lat,
	input  wire logic [7:0]          berrOfs,
	output logic                     memAck,
	output logic                     memBerr,
	output logic [15:0]              memData
);
	logic [15:0] words [0:31];
	logic [3:0]  waitCnt;

	// frame image, loaded by the bench before each return
	task put(input int i, input logic [15:0] d);
		words[i] = d;
	endtask : put

	//------
	// answer
	//------
	// idle data toggles every cycle so a stale word never looks fresh
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			memAck  <= 1'b0;
			memBerr <= 1'b0;
			memData <= 16'h0000;
			waitCnt <= 4'h0;
		end
		else
		begin
			memAck  <= 1'b0;
			memBerr <= 1'b0;
			memData <= ~memData;
			if (memReq && !memAck && !memBerr)
			begin
				if (waitCnt != lat)
					waitCnt <= waitCnt + 4'h1;
				else
				begin
					waitCnt <= 4'h0;
					// a faulting offset ends the read with a bus error
					if (memAddr[7:0] == berrOfs)
						memBerr <= 1'b1;
					else
					begin
						memAck  <= 1'b1;
						memData <= words[memAddr[5:1]];
					end
				end
			end
		end
	end
endmodule : aefr_stack_mem
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the address error and frame return unit
`timescale 1ns/1ps
`default_nettype none
`include "aefr_cfg.svh"
module tb
	import aefr_pkg::*;
;
	logic                clk, rst, excBusy, rteReq, memReq, memAck, memBerr;
	logic                abortCycle, rteDone, retryReq, retryRmw, retryByte, halted;
	logic                psel, penable, pwrite, pready, pslverr, e;
	aefr_access_t        coreAcc;
	aefr_exc_t           exc;
	logic [`AEFR_AW-1:0] stackPtr, memAddr, newStackPtr, retryAddr;
	logic [15:0]         memData, restSr;
	logic [31:0]         restPc, prdata, pwdata, q;
	logic [11:0]         paddr;
	logic [3:0]          lat;
	logic [7:0]          berrOfs;
	logic [2:0]          ev, rtry;
	logic [7:0]          rdLog[$];
	int                  errorCnt, checked, cyc, reqCnt;
	logic [23:0]         ta[6] = '{24'h101, 24'h101, 24'h103, 24'h105, 24'h100, 24'h102};
	aefr_size_t          ts[6] = '{AEFR_SZ_BYTE, AEFR_SZ_WORD, AEFR_SZ_LONG, AEFR_SZ_WORD,
		AEFR_SZ_WORD, AEFR_SZ_LONG};
	logic [5:0]          te = 6'b001110;
	logic [5:0]          tf = 6'b001000;
	logic [15:0]         sw[3] = '{16'h0800, 16'h0200, 16'h8800};
	logic [7:0]          bo[3] = '{8'h06, 8'h38, 8'h10};

	aefr_exc_unit dut(.clk, .rst, .coreAcc, .excBusy, .rteReq, .stackPtr, .memReq, .memAddr,
		.memAck, .memBerr, .memData, .abortCycle, .exc, .rteDone, .restSr, .restPc,
		.newStackPtr, .retryReq, .retryAddr, .retryRmw, .retryByte, .halted, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
	aefr_stack_mem mem(.clk, .rst, .memReq, .memAddr, .lat, .berrOfs, .memAck, .memBerr,
		.memData);

	//------
	// clock, watchdog and bus monitor
	//------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// a hang counts as a mismatch and still reaches the verdict
	always @(posedge clk)
	begin
		cyc++;
		if (memAck === 1'b1)
			rdLog.push_back(memAddr[7:0]);
		if (memReq === 1'b1)
			reqCnt++;
		if (cyc == 6000)
		begin
			errorCnt++;
			finishTest();
		end
	end

	//------
	// tasks
	//------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task finishTest;
		$display("checks %0d mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finishTest

	// one apb transfer; held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task doReset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `AEFR_REG_CTRL, 32'h0);
		chk(q, 32'h0);
		// only the low nibble is kept as the frame version
		apb(1'b1, `AEFR_REG_CTRL, 32'h35);
	endtask : doReset

	// one core access; the answer is looked at one edge later
	task acc(input logic [23:0] a, input aefr_size_t s, input logic f, p, b);
		@(posedge clk);
		coreAcc <= '{valid:1'b1, addr:a, size:s, fetch:f, write:1'b0, rmw:1'b0,
			pmovUpper:p, fc:3'h5};
		excBusy <= b;
		@(posedge clk);
		coreAcc.valid <= 1'b0;
		excBusy <= 1'b0;
		#1;
	endtask : acc

	task frame(input logic [15:0] f, v, s);
		for (int i = 0; i < 32; i++)
			mem.put(i, 16'h0000);
		mem.put(0, 16'h2700);
		mem.put(1, 16'h0001);
		mem.put(2, 16'h2340);
		mem.put(3, f);
		mem.put(4, s);
		mem.put(5, 16'h0001);
		mem.put(6, 16'h2345);
		mem.put(13, v);
	endtask : frame

	// run one return; ev is {halted, exception, done} at the first event
	task return_from_exception_instr(input logic [3:0] l, input logic [7:0] b);
		lat <= l;
		berrOfs <= b;
		rdLog.delete();
		@(posedge clk);
		rteReq <= 1'b1;
		@(posedge clk);
		rteReq <= 1'b0;
		ev = 3'h0;
		for (int n = 0; n < 400 && ev == 3'h0; n++)
		begin
			@(posedge clk);
			#1;
			ev = {halted, exc.start, rteDone};
			rtry = {retryReq, retryRmw, retryByte};
		end
	endtask : return_from_exception_instr

	//------
	// main sequence
	//------
	initial
	begin
		rst = 1'b1;
		coreAcc = '0;
		{excBusy, rteReq, psel, penable, pwrite} = 5'h0;
		stackPtr = 24'h000400;
		paddr = 12'h0;
		pwdata = 32'h0;
		lat = 4'h0;
		berrOfs = 8'hff;
		doReset();
		apb(1'b0, `AEFR_REG_CTRL, 32'h0);
		chk(q, 32'h5);
		apb(1'b1, `AEFR_REG_STAT, 32'hffff_ffff);
		apb(1'b0, `AEFR_REG_STAT, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		// odd operands per size and kind; bytes and even words pass
		for (int i = 0; i < 6; i++)
		begin
			acc(ta[i], ts[i], tf[i], i[0], 1'b0);
			chk(exc.start, te[i]);
			chk(abortCycle, te[i]);
			if (te[i])
			begin
				chk(exc.vector, `AEFR_VEC_AERR);
				chk(exc.longFrame, 1'b1);
				chk(exc.faultAddr, ta[i]);
				chk(exc.ssw[10], i[0]);
				chk({exc.ssw[13:12], exc.ssw[2:0]}, {tf[i], ~tf[i], 3'h5});
			end
		end
		apb(1'b0, `AEFR_REG_FADDR, 32'h0);
		chk(q, 32'h105);
		apb(1'b0, `AEFR_REG_SSW, 32'h0);
		chk(q, 32'h0000_2505);
		acc(24'h107, AEFR_SZ_WORD, 1'b0, 1'b0, 1'b1);
		chk({halted, exc.start}, 2'b10);
		acc(24'h109, AEFR_SZ_WORD, 1'b0, 1'b0, 1'b0);
		chk(exc.start, 1'b0);
		doReset();
		chk(halted, 1'b0);
		frame(16'h0000, 16'h0, 16'h0);
		return_from_exception_instr(4'h2, 8'hff);
		chk(ev, 3'h1);
		chk(restSr, 16'h2700);
		chk(restPc, 32'h0001_2340);
		chk(newStackPtr, 24'h000408);
		chk(rdLog.size(), 4);
		frame(16'h3000, 16'h0, 16'h0);
		return_from_exception_instr(4'h0, 8'hff);
		chk(ev, 3'h2);
		chk(exc.vector, `AEFR_VEC_FMTERR);
		frame(16'h8000, 16'h0800, 16'h0);
		return_from_exception_instr(4'h1, 8'hff);
		chk(ev, 3'h2);
		chk(exc.vector, `AEFR_VEC_FMTERR);
		chk(rdLog.size(), 5);
		chk(rdLog[4], 8'h1a);
		chk(newStackPtr, 24'h000408);
		apb(1'b0, `AEFR_REG_STAT, 32'h0);
		chk(q, 32'h0002_0e00);
		// rerun with rmw, rerun of a byte, software-completed cycle
		for (int i = 0; i < 3; i++)
		begin
			frame(16'h8000, 16'h97ff, sw[i]);
			return_from_exception_instr(i[3:0], 8'hff);
			chk(ev, 3'h1);
			chk(newStackPtr, 24'h00043a);
			chk(rdLog[5], 8'h38);
			chk(rtry[2], i != 2);
			if (i < 2)
				chk({rtry[1:0], retryAddr}, {(i == 0) ? 2'b10 : 2'b01, 24'h012345});
			@(posedge clk);
			#1;
			chk(exc.start, i == 0);
			if (i == 0)
				chk({exc.vector, exc.faultAddr}, {`AEFR_VEC_AERR, 24'h012345});
		end
		// bus error on the format word, on the probe, then on a later word
		for (int i = 0; i < 3; i++)
		begin
			frame(16'h8000, 16'h97ff, 16'h8000);
			return_from_exception_instr(4'h1, bo[i]);
			chk(ev, (i == 2) ? 3'h4 : 3'h2);
			if (i < 2)
				chk(exc.vector, `AEFR_VEC_BERR);
		end
		reqCnt = 0;
		return_from_exception_instr(4'h0, 8'hff);
		chk(reqCnt, 0);
		doReset();
		finishTest();
	end
endmodule : tb
`default_nettype wire
